// ### core/overtemp_trip_map.svh
`ifndef OVERTEMP_TRIP_MAP_SVH
`define OVERTEMP_TRIP_MAP_SVH
// register indices; the byte address is four times the index
`define OTT_IDX_LIMIT_Z1   8'hc4
`define OTT_IDX_LIMIT_Z3   8'hc5
`define OTT_IDX_LIMIT_Z2   8'hc9
`define OTT_IDX_STATUS     8'hca
`define OTT_IDX_OUT_EN     8'hcb
`define OTT_IDX_CONTROL    8'hd0
`define OTT_IDX_IRQ_STAT   8'hd1
`define OTT_IDX_IRQ_MASK   8'hd2
// reset values
`define OTT_RST_LIMIT      8'h7f
`define OTT_RST_STATUS     3'h0
`define OTT_RST_OUT_EN     3'h0
`define OTT_RST_LOCK       1'h0
`define OTT_RST_IRQ        3'h0
// status / enable bit positions
`define OTT_BIT_AMB        0
`define OTT_BIT_RD1        1
`define OTT_BIT_RD2        2
// control register bits
`define OTT_BIT_LOCK       0
// consecutive over-limit cycles needed
`define OTT_QUAL_COUNT     2
`endif

// ### core/overtemp_trip_pkg.sv
package overtemp_trip_pkg;
  typedef logic [7:0] temp_t;
  typedef logic [2:0] zone_vec_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_e;
endpackage

// ### core/overtemp_zone_qual.sv
`timescale 1ns/10ps
`include "overtemp_trip_map.svh"
// per-zone compare and two-cycle qualification
module overtemp_zone_qual
  import overtemp_trip_pkg::*;
#(
  parameter int QUAL = `OTT_QUAL_COUNT
) (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  // monitoring cycle
  input  wire logic   i_sample,
  input  wire temp_t  i_temp,
  input  wire temp_t  i_limit,
  // qualified over-limit level
  output logic        o_over
);
  // refuse counts that the four-bit run counter cannot hold
  if (QUAL < 1 || QUAL > 15) begin : g_bad_qual
    $error("QUAL out of range");
  end

  logic [3:0] run_q;
  // own trip limit only, never the interrupt high limit
  wire        above = i_temp > i_limit; // [R3]
  wire  [3:0] run_d = above ? ((run_q == 4'(QUAL)) ? run_q : run_q + 4'h1)
                            : 4'h0;

  // count consecutive monitoring cycles above the limit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q <= 4'h0;
    end else if (i_sample) begin
      run_q <= run_d;
    end
  end

  assign o_over = (run_q == 4'(QUAL)); // [R5]
endmodule

// ### core/overtemp_trip_monitor.sv
`timescale 1ns/10ps
`include "overtemp_trip_map.svh"
// Notes on behaviour
// [R1] three trip limit registers for diode 1, ambient, diode 2 reset to 7f.
// [R2] while the lock bit is set, limit and output enable writes are ignored.
// [R3] the trip compare uses its own limit, not the interrupt high limit.
// [R4] a zone over its trip limit sets its trip status bit.
// [R5] a zone counts as over only after two consecutive monitoring cycles.
// [R6] per-zone output enable (default off) gates the active-low trip pin.
// [R7] status: ambient bit 0, diode 1 bit 1, diode 2 bit 2, rest zero.
// [R8] writing one clears a status bit only if its event has ended.
// [R9] a set status bit stays set until software writes one to it.
// [R10] a rising edge of supply power good resets the status register.
// [R11] the trip pin releases once no enabled zone is still over.
module overtemp_trip_monitor
  import overtemp_trip_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESET_N,
  // temperature readings, one per monitoring cycle
  input  wire logic        I_SAMPLE,
  input  wire temp_t       I_TEMP_RD1,
  input  wire temp_t       I_TEMP_AMB,
  input  wire temp_t       I_TEMP_RD2,
  // supply power good pin
  input  wire logic        I_SUPPLY_POWER_GOOD,
  // axi4-lite write address
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [11:0] I_AWADDR,
  // axi4-lite write data
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  // axi4-lite write response
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  // axi4-lite read address
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [11:0] I_ARADDR,
  // axi4-lite read data
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  // trip pin and interrupt
  output logic             O_OVERTEMP_SHUTDOWN_N,
  output logic             O_IRQ
);
  // register state
  temp_t     limit_z1_q, limit_z2_q, limit_z3_q;
  zone_vec_t status_q, out_en_q, irq_stat_q, irq_mask_q;
  logic      lock_q;
  // bus state
  logic        aw_full_q, w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        wlane0_q;
  logic        bvalid_q, arready_q, rvalid_q;
  logic        awready_q, wready_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        trip_n_q, irq_q;
  // power good synchroniser
  logic [2:0]  pg_sync_q;
  logic        pg_state_q;

  // word index of a byte address
  function automatic logic [7:0] word_idx(input logic [11:0] a);
    return a[9:2];
  endfunction

  // known register index check
  function automatic logic is_mapped(input logic [7:0] idx);
    return idx == `OTT_IDX_LIMIT_Z1 || idx == `OTT_IDX_LIMIT_Z2 ||
           idx == `OTT_IDX_LIMIT_Z3 || idx == `OTT_IDX_STATUS   ||
           idx == `OTT_IDX_OUT_EN   || idx == `OTT_IDX_CONTROL  ||
           idx == `OTT_IDX_IRQ_STAT || idx == `OTT_IDX_IRQ_MASK;
  endfunction

  // zone qualification, vector indexed by status bit position
  zone_vec_t over;
  overtemp_zone_qual u_q_amb (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_sample  (I_SAMPLE),
    .i_temp    (I_TEMP_AMB),
    .i_limit   (limit_z2_q),
    .o_over    (over[`OTT_BIT_AMB])
  );
  overtemp_zone_qual u_q_rd1 (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_sample  (I_SAMPLE),
    .i_temp    (I_TEMP_RD1),
    .i_limit   (limit_z1_q),
    .o_over    (over[`OTT_BIT_RD1])
  );
  overtemp_zone_qual u_q_rd2 (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_sample  (I_SAMPLE),
    .i_temp    (I_TEMP_RD2),
    .i_limit   (limit_z3_q),
    .o_over    (over[`OTT_BIT_RD2])
  );

  // power good edge: change counts once stages two and three agree
  wire pg_agree = (pg_sync_q[1] == pg_sync_q[2]);
  wire pg_rise  = pg_agree && pg_sync_q[2] && !pg_state_q; // [R10]

  // write decode: fires when address and data are both held
  wire       wr_fire  = aw_full_q && w_full_q && !bvalid_q;
  wire [7:0] wr_idx   = word_idx(awaddr_q);
  wire       wr_ok    = is_mapped(wr_idx);
  wire       wr_en    = wr_fire && wlane0_q;
  wire       wr_cfg   = wr_en && !lock_q; // [R2]
  wire       wr_lim1  = wr_cfg && wr_idx == `OTT_IDX_LIMIT_Z1;
  wire       wr_lim2  = wr_cfg && wr_idx == `OTT_IDX_LIMIT_Z2;
  wire       wr_lim3  = wr_cfg && wr_idx == `OTT_IDX_LIMIT_Z3;
  wire       wr_oen   = wr_cfg && wr_idx == `OTT_IDX_OUT_EN;
  wire       wr_stat  = wr_en && wr_idx == `OTT_IDX_STATUS;
  wire       wr_ctrl  = wr_en && wr_idx == `OTT_IDX_CONTROL;
  wire       wr_istat = wr_en && wr_idx == `OTT_IDX_IRQ_STAT;
  wire       wr_imask = wr_en && wr_idx == `OTT_IDX_IRQ_MASK;
  wire [2:0] wbits    = wdata_q[2:0];

  // status: set wins, clear only where the event has ended
  wire [2:0] stat_clr = wr_stat ? (wbits & ~over) : 3'h0; // [R8]
  wire [2:0] stat_d   = (status_q & ~stat_clr) | over; // [R4] [R9]
  // interrupt: newly set trip bits are the events
  wire [2:0] new_trip = over & ~status_q;
  wire [2:0] ist_clr  = wr_istat ? wbits : 3'h0;
  wire [2:0] ist_d    = (irq_stat_q & ~ist_clr) | new_trip;

  // pin: low while any enabled zone is qualified over
  wire trip_active = |(over & out_en_q); // [R6] [R11]

  // read mux
  wire [7:0]  rd_idx = word_idx(I_ARADDR);
  wire        rd_ok  = is_mapped(rd_idx);
  wire [31:0] rd_val =
      (rd_idx == `OTT_IDX_LIMIT_Z1) ? {24'h0, limit_z1_q} :
      (rd_idx == `OTT_IDX_LIMIT_Z2) ? {24'h0, limit_z2_q} :
      (rd_idx == `OTT_IDX_LIMIT_Z3) ? {24'h0, limit_z3_q} :
      (rd_idx == `OTT_IDX_STATUS)   ? {29'h0, status_q}   : // [R7]
      (rd_idx == `OTT_IDX_OUT_EN)   ? {29'h0, out_en_q}   :
      (rd_idx == `OTT_IDX_CONTROL)  ? {31'h0, lock_q}     :
      (rd_idx == `OTT_IDX_IRQ_STAT) ? {29'h0, irq_stat_q} :
      (rd_idx == `OTT_IDX_IRQ_MASK) ? {29'h0, irq_mask_q} :
                                      32'h0;
  wire ar_take = I_ARVALID && arready_q;

  // power good synchroniser and settled level; the settled level starts
  // low, so a pin already high gives one rise after reset, harmless as
  // the status is clear then anyway
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pg_sync_q  <= 3'h0;
      pg_state_q <= 1'h0;
    end else begin
      pg_sync_q <= {pg_sync_q[1:0], I_SUPPLY_POWER_GOOD};
      if (pg_agree) begin
        pg_state_q <= pg_sync_q[2];
      end
    end
  end

  // write address and data capture, either order
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_full_q <= 1'h0;
      w_full_q  <= 1'h0;
      awaddr_q  <= 12'h0;
      wdata_q   <= 32'h0;
      wlane0_q  <= 1'h0;
    end else begin
      if (I_AWVALID && !aw_full_q) begin
        aw_full_q <= 1'h1;
        awaddr_q  <= I_AWADDR;
      end else if (wr_fire) begin
        aw_full_q <= 1'h0;
      end
      if (I_WVALID && !w_full_q) begin
        w_full_q <= 1'h1;
        wdata_q  <= I_WDATA;
        wlane0_q <= I_WSTRB[0];
      end else if (wr_fire) begin
        w_full_q <= 1'h0;
      end
    end
  end

  // readies mirror the hold flags as flops of their own, so the bus
  // never sees an inverter between a flop and the port
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      awready_q <= 1'h1;
      wready_q  <= 1'h1;
    end else begin
      if (I_AWVALID && !aw_full_q) begin
        awready_q <= 1'h0;
      end else if (wr_fire) begin
        awready_q <= 1'h1;
      end
      if (I_WVALID && !w_full_q) begin
        wready_q <= 1'h0;
      end else if (wr_fire) begin
        wready_q <= 1'h1;
      end
    end
  end

  // write response
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bvalid_q <= 1'h0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'h1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_q <= 1'h0;
    end
  end

  // read channel: one read in flight, answer registered
  // the address is decoded live, so it must stand until the take edge
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      arready_q <= 1'h1;
      rvalid_q  <= 1'h0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'h0;
      rvalid_q  <= 1'h1;
      rdata_q   <= rd_val;
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && I_RREADY) begin
      arready_q <= 1'h1;
      rvalid_q  <= 1'h0;
    end
  end

  // configuration registers; limits and output enable frozen by the lock bit
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      limit_z1_q <= `OTT_RST_LIMIT; // [R1]
      limit_z2_q <= `OTT_RST_LIMIT;
      limit_z3_q <= `OTT_RST_LIMIT;
      out_en_q   <= `OTT_RST_OUT_EN;
      lock_q     <= `OTT_RST_LOCK;
      irq_mask_q <= `OTT_RST_IRQ;
    end else begin
      if (wr_lim1) limit_z1_q <= wdata_q[7:0];
      if (wr_lim2) limit_z2_q <= wdata_q[7:0];
      if (wr_lim3) limit_z3_q <= wdata_q[7:0];
      if (wr_oen)  out_en_q   <= wbits;
      // lock is sticky until reset, so software cannot unlock
      if (wr_ctrl && wdata_q[`OTT_BIT_LOCK]) lock_q <= 1'h1;
      if (wr_imask) irq_mask_q <= wbits;
    end
  end

  // trip status, cleared by power good rising ahead of new events;
  // a zone still over sets its bit again one cycle later
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      status_q   <= `OTT_RST_STATUS;
      irq_stat_q <= `OTT_RST_IRQ;
    end else begin
      status_q   <= pg_rise ? `OTT_RST_STATUS : stat_d; // [R10]
      irq_stat_q <= ist_d;
    end
  end

  // registered pin and interrupt outputs
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      trip_n_q <= 1'h1;
      irq_q    <= 1'h0;
    end else begin
      trip_n_q <= !trip_active; // [R6] [R11]
      irq_q    <= |(ist_d & irq_mask_q);
    end
  end

  // bus channel outputs
  assign O_AWREADY             = awready_q;
  assign O_WREADY              = wready_q;
  assign O_BVALID              = bvalid_q;
  assign O_BRESP               = bresp_q;
  assign O_ARREADY             = arready_q;
  assign O_RVALID              = rvalid_q;
  assign O_RDATA               = rdata_q;
  assign O_RRESP               = rresp_q;
  // trip pin and interrupt
  assign O_OVERTEMP_SHUTDOWN_N = trip_n_q;
  assign O_IRQ                 = irq_q;
endmodule

// ### verif/overtemp_trip_assertions.sv
`timescale 1ns/10ps
// bus handshake and trip pin relations seen at the monitor ports
module overtemp_trip_assertions (
  // clock and reset
  input wire logic        I_CLK,
  input wire logic        I_RESET_N,
  // monitoring strobe and trip pin
  input wire logic        I_SAMPLE,
  input wire logic        O_OVERTEMP_SHUTDOWN_N,
  // register bus
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  logic [1:0] nsmp_q;
  // samples since reset, saturating: a trip needs two of them
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) nsmp_q <= 2'h0;
    else if (I_SAMPLE && nsmp_q != 2'h2) nsmp_q <= nsmp_q + 2'h1;
  end
  a_pin_qualified: assert property (
    $fell(O_OVERTEMP_SHUTDOWN_N) |-> nsmp_q == 2'h2) else $error("early trip");
  a_write_answer: assert property (
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
    else $error("write response late");
  a_write_single: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data late");
  a_read_single: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read data repeated");
  a_read_blocked: assert property (O_RVALID |-> !O_ARREADY)
    else $error("address taken during read");
  a_upper_zero: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_slverr_zero: assert property (
    O_RVALID && O_RRESP == 2'h2 |-> O_RDATA == 32'h0)
    else $error("error read with data");
endmodule
bind overtemp_trip_monitor overtemp_trip_assertions i_overtemp_trip_assertions (
  .I_CLK, .I_RESET_N, .I_SAMPLE, .O_OVERTEMP_SHUTDOWN_N, .I_AWVALID,
  .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID,
  .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA, .O_RRESP);

// ### verif/tb_overtemp_trip_monitor.sv
`timescale 1ns/10ps
module tb_overtemp_trip_monitor;
  import overtemp_trip_pkg::*;
  logic        clk, rst_n, smp, pg, awv, wv, br, arv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [7:0]  lim [3];
  logic [7:0]  lix [3];
  logic [2:0]  st, en, ov;
  temp_t       t [3];
  wire logic   awr, wrdy, bv, arr, rv, pin, irq;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  int          errors, total_checks, seed, n, z;
  int          cnt [3];
  overtemp_trip_monitor i_overtemp_trip_monitor (.I_CLK(clk),
    .I_RESET_N(rst_n), .I_SAMPLE(smp), .I_TEMP_RD1(t[1]), .I_TEMP_AMB(t[0]),
    .I_TEMP_RD2(t[2]), .I_SUPPLY_POWER_GOOD(pg), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(br),
    .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_OVERTEMP_SHUTDOWN_N(pin), .O_IRQ(irq));
  // free-running 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // a hung handshake is a mismatch and ends the run
  task timeout;
    errors++;
    finish_test;
  endtask
  task wr(input logic [7:0] ix, d, input logic [1:0] er);
    @(posedge clk);
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    awa <= {2'h0, ix, 2'h0};
    wd <= {24'h0, d};
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
      if (bv) break;
    end
    br <= 1'h0;
    if (n == 40) timeout;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task rd(input logic [7:0] ix, d, input logic [1:0] er);
    @(posedge clk);
    arv <= 1'h1;
    rr <= 1'h1;
    ara <= {2'h0, ix, 2'h0};
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      if (rv) break;
    end
    rr <= 1'h0;
    if (n == 40) timeout;
    chk("rdata", {24'h0, d}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  // one monitoring cycle; the model counts consecutive over-limit samples
  task sample;
    @(posedge clk);
    smp <= 1'h1;
    for (z = 0; z < 3; z++) begin
      cnt[z] = (t[z] > lim[z]) ? cnt[z] + 1 : 0;
      ov[z] = cnt[z] >= 2;
    end
    st = st | ov;
    @(posedge clk);
    smp <= 1'h0;
    repeat (3) @(posedge clk);
    chk("pin", 32'(~|(ov & en)), 32'(pin));
  endtask
  task irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", 32'(e), 32'(irq));
  endtask
  initial begin
    seed = 3763;
    {rst_n, smp, awv, wv, br, arv, rr, st, en} = '0;
    {awa, ara, wd} = '0;
    ws = 4'hf;
    pg = 1'h1;
    t = '{8'h10, 8'h10, 8'h10};
    cnt = '{0, 0, 0};
    lim = '{8'h7f, 8'h7f, 8'h7f};
    lix = '{8'hc9, 8'hc4, 8'hc5};
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    for (z = 0; z < 3; z++) rd(lix[z], lim[z], 2'h0);
    rd(8'hca, 8'h00, 2'h0);
    rd(8'hcb, 8'h00, 2'h0);
    rd(8'h05, 8'h00, 2'h2);
    wr(8'h05, 8'h5a, 2'h2);
    // random limits kept in the model; the start temperature stays below
    for (z = 0; z < 3; z++) begin
      lim[z] = 8'h20 + 8'($random(seed) & 32'h3f);
      wr(lix[z], lim[z], 2'h0);
    end
    for (z = 0; z < 3; z++) rd(lix[z], lim[z], 2'h0);
    // a write without byte lane 0 leaves the register alone
    ws <= 4'he;
    wr(lix[2], 8'h11, 2'h0);
    ws <= 4'hf;
    rd(lix[2], lim[2], 2'h0);
    en = 3'h1;
    wr(8'hcb, 8'h01, 2'h0);
    wr(8'hd2, 8'h01, 2'h0);
    // diode 1 sits exactly on its own limit: strict compare, no trip
    t[0] <= lim[0] + 8'h1;
    t[1] <= lim[1];
    sample;
    rd(8'hca, {5'h0, st}, 2'h0);
    sample;
    rd(8'hca, {5'h0, st}, 2'h0);
    irq_is(1'h1);
    wr(8'hca, 8'h07, 2'h0);
    rd(8'hca, 8'h01, 2'h0);
    wr(8'hd2, 8'h00, 2'h0);
    irq_is(1'h0);
    wr(8'hd2, 8'h01, 2'h0);
    irq_is(1'h1);
    wr(8'hd1, 8'h01, 2'h0);
    irq_is(1'h0);
    t[0] <= lim[0];
    sample;
    rd(8'hca, {5'h0, st}, 2'h0);
    wr(8'hca, 8'h01, 2'h0);
    st = 3'h0;
    rd(8'hca, 8'h00, 2'h0);
    // diode 2 trips with its pin enable off, then falls back
    t[2] <= lim[2] + 8'h1;
    sample;
    sample;
    t[2] <= lim[2];
    sample;
    rd(8'hca, {5'h0, st}, 2'h0);
    // diode 1 trips with its own enable set, then falls back
    en = 3'h2;
    wr(8'hcb, 8'h02, 2'h0);
    t[1] <= lim[1] + 8'h1;
    sample;
    sample;
    t[1] <= lim[1];
    sample;
    rd(8'hca, {5'h0, st}, 2'h0);
    pg <= 1'h0;
    repeat (4) @(posedge clk);
    pg <= 1'h1;
    repeat (8) @(posedge clk);
    st = 3'h0;
    rd(8'hca, 8'h00, 2'h0);
    wr(8'hd0, 8'h01, 2'h0);
    wr(lix[1], 8'h11, 2'h0);
    rd(lix[1], lim[1], 2'h0);
    wr(8'hcb, 8'h07, 2'h0);
    rd(8'hcb, {5'h0, en}, 2'h0);
    finish_test;
  end
endmodule
